// [rtl/hmd_ctrl.sv]
// haptic driver control: operating modes, I2C registers, detect and library fetch
// Behaviour
// - hold everything reset until regulator good
// - power-down clears registers, I2C unreachable
// - leave power-down alone when supplies good and shutdown pin high
// - standby: I2C and SRAM writes allowed
// - playback request enters active, drive enabled
// - playback complete returns to standby
// - 0xAA at 0x00 resets, SRAM kept
// - 10-bit result in high/low registers
// - battery volts are 6.1 code/1023
// - resistance is 610 code/(1023 gain)
// - reference plus mode bit enable compensation
// - mode field selects; triggers override
// - SRAM split at base: library, FIFO
// - library/trigger from SRAM, stream from FIFO
// - base byte is version, not waveform
// - 4-byte header entries, start then end
// - header one follows base, four-byte steps
// - samples are two's-complement signed
// - clock enable bit gates SRAM clock
`default_nettype none
module hmd_ctrl
  import hmd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // supply and pins
  input wire logic regulatorGood,
  input wire logic shutdownPinN,
  input wire logic [NUM_TRIG-1:0] trigPin,
  // i2c open-drain pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // measurement front end
  input wire logic [9:0] measCode,
  input wire logic measValid,
  // playback engines
  input wire logic engineDone,
  output logic playStart,
  output logic [1:0] playSource,
  output logic contFiltered,
  output logic signed [7:0] sampleOut,
  output logic sampleValid,
  // sram port
  output logic sramClockOn,
  output logic sramClear,
  output logic [SRAM_AW-1:0] sramRdAddr,
  output logic sramRdEn,
  input wire logic [7:0] sramRdData,
  output logic [SRAM_AW-1:0] sramWrAddr,
  output logic [7:0] sramWrData,
  output logic sramWrEn,
  output logic [SRAM_AW-1:0] fifoBase,
  // analog controls
  output logic [1:0] opMode,
  output logic boostEnable,
  output logic bridgeEnable,
  output logic detectRun,
  output logic [1:0] detectSeq,
  output logic [5:0] measGain,
  output logic compEnable,
  output logic [6:0] vbatRef
);
  typedef enum logic [2:0] {I_IDLE, I_DEV, I_REG, I_WR, I_RD} hmd_i2c_t;
  typedef enum logic [1:0] {LB_IDLE, LB_HDR, LB_DATA} hmd_lib_t;

  logic [1:0] regGoodSync_q, shutSync_q, sclSync_q, sdaSync_q;
  logic sclDly_q, sdaDly_q;
  logic [NUM_TRIG-1:0] trigDly_q, trigEdge;
  logic pdown, cfgRst, soft_reset_key_q;
  logic sclRise, sclFall, i2cStart, i2cStop;
  hmd_i2c_t i2cState_q;
  logic [3:0] bitCnt_q;
  logic ackPhase_q, readDir_q;
  logic [7:0] shift_q, txShift_q, ptr_q, rdData;
  logic wrEn_q;
  logic [7:0] wrAddr_q, wrData_q;
  hmd_play_t playMode_q;
  logic contFilt_q, go_q, sramClk_q, compMode_q, detGo_q, detGoDly_q;
  logic [6:0] waveId_q, vbatRef_q;
  logic [6:0] trigId_q [NUM_TRIG];
  logic [12:0] base_q, ramPtr_q;
  logic [1:0] detSeq_q;
  logic [5:0] gain_q;
  logic [9:0] result_q;
  hmd_mode_t mode_q;
  hmd_lib_t lib_q;
  logic [1:0] lbIdx_q;
  logic lbPend_q, libDone_q, startReq;
  logic [6:0] startId;
  logic [12:0] lbAddr_q, lbEnd_q;
  logic [7:0] startHigh_q;

  // pin synchronisers, reset only by the power-on input
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regGoodSync_q <= 2'h0;
      shutSync_q <= 2'h0;
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclDly_q <= 1'b1;
      sdaDly_q <= 1'b1;
    end else begin
      regGoodSync_q <= {regGoodSync_q[0], regulatorGood};
      shutSync_q <= {shutSync_q[0], shutdownPinN};
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclDly_q <= sclSync_q[1];
      sdaDly_q <= sdaSync_q[1];
    end
  end

  // supplies good and pin high is the only way out of power-down
  assign pdown = !regGoodSync_q[1] || !shutSync_q[1];
  assign cfgRst = !rst_n || pdown || soft_reset_key_q;

  assign sclRise = sclSync_q[1] && !sclDly_q;
  assign sclFall = !sclSync_q[1] && sclDly_q;
  assign i2cStart = sclSync_q[1] && sclDly_q && !sdaSync_q[1] && sdaDly_q;
  assign i2cStop = sclSync_q[1] && sclDly_q && sdaSync_q[1] && !sdaDly_q;

  // register read mux
  always_comb begin
    rdData = 8'h00;
    unique case (ptr_q)
      REG_STATUS: rdData = {6'h00, mode_q};
      REG_PLAYBACK_MODE_SELECT: rdData = {5'h00, contFilt_q, playMode_q};
      REG_WAVE_ID: rdData = {1'b0, waveId_q};
      REG_BASE_HIGH: rdData = {3'h0, base_q[12:8]};
      REG_BASE_LOW: rdData = base_q[7:0];
      REG_RAM_ADDR_HIGH: rdData = {3'h0, ramPtr_q[12:8]};
      REG_RAM_ADDR_LOW: rdData = ramPtr_q[7:0];
      REG_SRAM_CLK: rdData = {7'h00, sramClk_q};
      REG_COMP_MODE: rdData = {7'h00, compMode_q};
      REG_DETECT_CTRL: rdData = {detGo_q, vbatRef_q};
      REG_DETECT_CFG: rdData = {gain_q, detSeq_q};
      REG_MEAS_HIGH: rdData = {6'h00, result_q[9:8]};
      REG_MEAS_LOW: rdData = result_q[7:0];
      default: begin
        for (int t = 0; t < NUM_TRIG; t++) begin
          if (ptr_q == REG_TRIG_ID0 + 8'(t)) begin
            rdData = {1'b0, trigId_q[t]};
          end
        end
      end
    endcase
  end

  // i2c slave, held in reset through power-down
  always_ff @(posedge clk_sys) begin
    if (cfgRst) begin
      i2cState_q <= I_IDLE;
      bitCnt_q <= 4'h0;
      ackPhase_q <= 1'b0;
      readDir_q <= 1'b0;
      shift_q <= 8'h00;
      txShift_q <= 8'h00;
      ptr_q <= 8'h00;
      sdaOe <= 1'b0;
      wrEn_q <= 1'b0;
      wrAddr_q <= 8'h00;
      wrData_q <= 8'h00;
    end else begin
      wrEn_q <= 1'b0;
      if (i2cStart) begin
        i2cState_q <= I_DEV;
        bitCnt_q <= 4'h0;
        ackPhase_q <= 1'b0;
        sdaOe <= 1'b0;
      end else if (i2cStop) begin
        i2cState_q <= I_IDLE;
        sdaOe <= 1'b0;
      end else if (i2cState_q != I_IDLE) begin
        if (sclRise) begin
          if (ackPhase_q) begin
            if (i2cState_q == I_RD && sdaSync_q[1]) begin
              i2cState_q <= I_IDLE;
            end
          end else begin
            shift_q <= {shift_q[6:0], sdaSync_q[1]};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end else if (sclFall) begin
          if (!ackPhase_q && bitCnt_q == 4'h8) begin
            ackPhase_q <= 1'b1;
            bitCnt_q <= 4'h0;
            sdaOe <= 1'b1;
            unique case (i2cState_q)
              I_DEV: begin
                readDir_q <= shift_q[0];
                if (shift_q[7:1] != I2C_DEV_ADDR) begin
                  i2cState_q <= I_IDLE;
                  sdaOe <= 1'b0;
                end
              end
              I_REG: ptr_q <= shift_q;
              I_WR: begin
                wrEn_q <= 1'b1;
                wrAddr_q <= ptr_q;
                wrData_q <= shift_q;
                ptr_q <= ptr_q + 8'h01;
              end
              I_RD: sdaOe <= 1'b0;
              I_IDLE: sdaOe <= 1'b0;
            endcase
          end else if (ackPhase_q) begin
            ackPhase_q <= 1'b0;
            sdaOe <= 1'b0;
            if (i2cState_q == I_DEV) begin
              i2cState_q <= readDir_q ? I_RD : I_REG;
            end else if (i2cState_q == I_REG) begin
              i2cState_q <= I_WR;
            end
            if ((i2cState_q == I_DEV && readDir_q) || i2cState_q == I_RD) begin
              txShift_q <= rdData;
              sdaOe <= !rdData[7];
              ptr_q <= ptr_q + 8'h01;
            end
          end else if (i2cState_q == I_RD) begin
            txShift_q <= {txShift_q[6:0], 1'b0};
            sdaOe <= !txShift_q[6];
          end
        end
      end
    end
  end

  // open drain: the pin is only ever pulled low
  always_ff @(posedge clk_sys) begin
    sdaOut <= 1'b0;
  end

  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (cfgRst) begin
      soft_reset_key_q <= 1'b0;
      playMode_q <= hmd_play_t'(PLAYBACK_MODE_SELECT_RST);
      contFilt_q <= 1'b0;
      go_q <= 1'b0;
      waveId_q <= 7'h00;
      for (int t = 0; t < NUM_TRIG; t++) begin
        trigId_q[t] <= 7'h00;
      end
      base_q <= BASE_RST;
      sramClk_q <= 1'b0;
      compMode_q <= 1'b0;
      detGo_q <= 1'b0;
      vbatRef_q <= VBAT_REF_RST;
      detSeq_q <= 2'h0;
      gain_q <= GAIN_RST;
    end else begin
      go_q <= 1'b0;
      if (wrEn_q) begin
        unique case (wrAddr_q)
          REG_SOFT_RESET: soft_reset_key_q <= (wrData_q == SOFT_RESET_KEY);
          REG_PLAYBACK_MODE_SELECT: begin
            playMode_q <= hmd_play_t'(wrData_q[1:0]);
            contFilt_q <= wrData_q[FLD_CONT_FILTER];
          end
          REG_PLAY_GO: go_q <= wrData_q[0];
          REG_WAVE_ID: waveId_q <= wrData_q[6:0];
          REG_BASE_HIGH: base_q[12:8] <= wrData_q[4:0];
          REG_BASE_LOW: base_q[7:0] <= wrData_q;
          REG_SRAM_CLK: sramClk_q <= wrData_q[0];
          REG_COMP_MODE: compMode_q <= wrData_q[0];
          REG_DETECT_CTRL: begin
            detGo_q <= wrData_q[FLD_DETECT_GO];
            vbatRef_q <= wrData_q[6:0];
          end
          REG_DETECT_CFG: begin
            detSeq_q <= wrData_q[1:0];
            gain_q <= wrData_q[7:FLD_GAIN_LSB];
          end
          default: begin
            for (int t = 0; t < NUM_TRIG; t++) begin
              if (wrAddr_q == REG_TRIG_ID0 + 8'(t)) begin
                trigId_q[t] <= wrData_q[6:0];
              end
            end
          end
        endcase
      end
    end
  end

  // sram load port; blocked while a waveform plays so reads never collide
  always_ff @(posedge clk_sys) begin
    if (!rst_n || pdown) begin
      ramPtr_q <= 13'h0000;
      sramWrEn <= 1'b0;
      sramWrAddr <= 13'h0000;
      sramWrData <= 8'h00;
    end else begin
      sramWrEn <= 1'b0;
      if (wrEn_q && wrAddr_q == REG_RAM_DATA && mode_q == OM_STANDBY && sramClk_q) begin
        sramWrEn <= 1'b1;
        sramWrAddr <= ramPtr_q;
        sramWrData <= wrData_q;
        ramPtr_q <= ramPtr_q + 13'h0001;
      end else if (wrEn_q && wrAddr_q == REG_RAM_ADDR_HIGH) begin
        ramPtr_q[12:8] <= wrData_q[4:0];
      end else if (wrEn_q && wrAddr_q == REG_RAM_ADDR_LOW) begin
        ramPtr_q[7:0] <= wrData_q;
      end
    end
  end

  // measurement: result survives until the next rising detect go
  always_ff @(posedge clk_sys) begin
    if (cfgRst) begin
      detGoDly_q <= 1'b0;
      result_q <= 10'h000;
    end else begin
      detGoDly_q <= detGo_q;
      if (detGo_q && !detGoDly_q) begin
        result_q <= 10'h000;
      end else if (detGo_q && sramClk_q && measValid) begin
        result_q <= measCode;
      end
    end
  end

  // trigger pin synchronisers and rising-edge detect
  generate
    for (genvar g = 0; g < NUM_TRIG; g++) begin : gTrig
      logic [1:0] sync_q;
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          sync_q <= 2'h0;
          trigDly_q[g] <= 1'b0;
        end else begin
          sync_q <= {sync_q[0], trigPin[g]};
          trigDly_q[g] <= sync_q[1];
        end
      end
      assign trigEdge[g] = sync_q[1] && !trigDly_q[g];
    end
  endgenerate

  // lowest-numbered trigger wins over the go bit
  always_comb begin
    startReq = go_q;
    startId = waveId_q;
    for (int t = NUM_TRIG - 1; t >= 0; t--) begin
      if (trigEdge[t]) begin
        startReq = 1'b1;
        startId = trigId_q[t];
      end
    end
  end

  // operating mode
  always_ff @(posedge clk_sys) begin
    if (cfgRst) begin
      mode_q <= pdown ? OM_DOWN : OM_STANDBY;
      playStart <= 1'b0;
      playSource <= PM_LIBRARY;
    end else begin
      playStart <= 1'b0;
      unique case (mode_q)
        OM_DOWN: mode_q <= OM_STANDBY;
        OM_STANDBY: begin
          if (startReq) begin
            mode_q <= OM_ACTIVE;
            playStart <= 1'b1;
            playSource <= (|trigEdge) ? PM_LIBRARY : playMode_q;
          end
        end
        OM_ACTIVE: begin
          if ((playSource == PM_LIBRARY && libDone_q)
              || (playSource != PM_LIBRARY && engineDone)) begin
            mode_q <= OM_STANDBY;
          end
        end
        default: mode_q <= OM_STANDBY;
      endcase
    end
  end

  // library fetch: header at base+1+4*(id-1), then signed samples
  always_ff @(posedge clk_sys) begin
    if (cfgRst) begin
      lib_q <= LB_IDLE;
      lbIdx_q <= 2'h0;
      lbPend_q <= 1'b0;
      lbAddr_q <= 13'h0000;
      lbEnd_q <= 13'h0000;
      startHigh_q <= 8'h00;
      libDone_q <= 1'b0;
      sramRdEn <= 1'b0;
      sramRdAddr <= 13'h0000;
      sampleOut <= 8'sh00;
      sampleValid <= 1'b0;
    end else begin
      libDone_q <= 1'b0;
      sramRdEn <= 1'b0;
      sampleValid <= 1'b0;
      unique case (lib_q)
        LB_IDLE: begin
          lbPend_q <= 1'b0;
          lbIdx_q <= 2'h0;
          if (mode_q == OM_STANDBY && startReq
              && ((|trigEdge) || playMode_q == PM_LIBRARY)) begin
            if (startId == 7'h00) begin
              libDone_q <= 1'b1;
            end else begin
              lib_q <= LB_HDR;
              lbAddr_q <= base_q + {4'h0, startId, 2'b00} - HDR_BACKSTEP;
            end
          end
        end
        LB_HDR: begin
          if (!lbPend_q) begin
            sramRdEn <= 1'b1;
            sramRdAddr <= lbAddr_q;
            lbPend_q <= 1'b1;
          end else begin
            lbPend_q <= 1'b0;
            lbIdx_q <= lbIdx_q + 2'h1;
            lbAddr_q <= lbAddr_q + 13'h0001;
            unique case (lbIdx_q)
              2'h0: startHigh_q <= sramRdData;
              2'h1: lbEnd_q <= {startHigh_q[4:0], sramRdData};
              2'h2: startHigh_q <= sramRdData;
              2'h3: begin
                lbAddr_q <= lbEnd_q;
                lbEnd_q <= {startHigh_q[4:0], sramRdData};
                lib_q <= LB_DATA;
              end
            endcase
          end
        end
        LB_DATA: begin
          if (!lbPend_q) begin
            sramRdEn <= 1'b1;
            sramRdAddr <= lbAddr_q;
            lbPend_q <= 1'b1;
          end else begin
            lbPend_q <= 1'b0;
            sampleOut <= $signed(sramRdData);
            sampleValid <= 1'b1;
            if (lbAddr_q == lbEnd_q) begin
              libDone_q <= 1'b1;
              lib_q <= LB_IDLE;
            end else begin
              lbAddr_q <= lbAddr_q + 13'h0001;
            end
          end
        end
        default: lib_q <= LB_IDLE;
      endcase
    end
  end

  // registered copies of the analog controls
  always_ff @(posedge clk_sys) begin
    if (cfgRst) begin
      opMode <= 2'h0;
      boostEnable <= 1'b0;
      bridgeEnable <= 1'b0;
      detectRun <= 1'b0;
      detectSeq <= 2'h0;
      measGain <= GAIN_RST;
      compEnable <= 1'b0;
      vbatRef <= VBAT_REF_RST;
      sramClockOn <= 1'b0;
      contFiltered <= 1'b0;
      fifoBase <= BASE_RST;
    end else begin
      opMode <= mode_q;
      boostEnable <= (mode_q == OM_ACTIVE);
      bridgeEnable <= (mode_q == OM_ACTIVE);
      detectRun <= detGo_q && sramClk_q;
      detectSeq <= detSeq_q;
      measGain <= gain_q;
      compEnable <= compMode_q;
      vbatRef <= vbatRef_q;
      sramClockOn <= sramClk_q;
      contFiltered <= contFilt_q;
      fifoBase <= base_q;
    end
  end

  // memory is wiped in power-down and while rst_n is low, never by the soft reset key
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sramClear <= 1'b1;
    end else begin
      sramClear <= pdown;
    end
  end
endmodule
`default_nettype wire

// [rtl/hmd_pkg.sv]
// constants and types shared by the haptic mode and detect controller
`default_nettype none
package hmd_pkg;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h5A;
  localparam int SRAM_AW = 13;
  // register offsets
  localparam logic [7:0] REG_SOFT_RESET = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_PLAYBACK_MODE_SELECT = 8'h08;
  localparam logic [7:0] REG_PLAY_GO = 8'h09;
  localparam logic [7:0] REG_WAVE_ID = 8'h0A;
  localparam logic [7:0] REG_TRIG_ID0 = 8'h0B;
  localparam logic [7:0] REG_BASE_HIGH = 8'h2D;
  localparam logic [7:0] REG_BASE_LOW = 8'h2E;
  localparam logic [7:0] REG_RAM_ADDR_HIGH = 8'h40;
  localparam logic [7:0] REG_RAM_ADDR_LOW = 8'h41;
  localparam logic [7:0] REG_RAM_DATA = 8'h42;
  localparam logic [7:0] REG_SRAM_CLK = 8'h45;
  localparam logic [7:0] REG_COMP_MODE = 8'h4C;
  localparam logic [7:0] REG_DETECT_CTRL = 8'h4D;
  localparam logic [7:0] REG_DETECT_CFG = 8'h4E;
  localparam logic [7:0] REG_MEAS_HIGH = 8'h4F;
  localparam logic [7:0] REG_MEAS_LOW = 8'h50;
  // field positions
  localparam int FLD_DETECT_GO = 7;
  localparam int FLD_CONT_FILTER = 2;
  localparam int FLD_GAIN_LSB = 2;
  // keys, reset values, header step, trigger count and enum types
  localparam logic [7:0] SOFT_RESET_KEY = 8'hAA;
  localparam logic [1:0] PLAYBACK_MODE_SELECT_RST = 2'h0;
  localparam logic [5:0] GAIN_RST = 6'h14;
  localparam logic [12:0] BASE_RST = 13'h0000;
  localparam logic [6:0] VBAT_REF_RST = 7'h00;
  localparam logic [12:0] HDR_BACKSTEP = 13'h0003;
  localparam int NUM_TRIG = 3;
  typedef enum logic [1:0] {PM_LIBRARY, PM_STREAM, PM_SQUARE} hmd_play_t;
  typedef enum logic [1:0] {OM_DOWN, OM_STANDBY, OM_ACTIVE} hmd_mode_t;
endpackage
`default_nettype wire

// [verif/hmd_ctrl_props.sv]
// concurrent checks on the haptic controller ports
`default_nettype none
module hmd_ctrl_props
  import hmd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pins and engines
  input wire logic regulatorGood,
  input wire logic shutdownPinN,
  input wire logic engineDone,
  // watched outputs
  input wire logic playStart,
  input wire logic [1:0] playSource,
  input wire logic sampleValid,
  input wire logic sramClockOn,
  input wire logic sramClear,
  input wire logic sramWrEn,
  input wire logic sdaOe,
  input wire logic [1:0] opMode,
  input wire logic boostEnable,
  input wire logic bridgeEnable,
  input wire logic detectRun,
  input wire logic [5:0] measGain
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence sDriveOn;
    opMode == 2'h2 && boostEnable && bridgeEnable;
  endsequence
  // supplies come up and stay up long enough for standby
  sequence sSuppliesUp;
    $rose(regulatorGood && shutdownPinN) ##1 (regulatorGood && shutdownPinN) [*7];
  endsequence
  chk_reset_values: assert property (
    $rose(rst_n) |-> sramClear && opMode == 2'h0 && measGain == 6'h14 && !boostEnable)
    else $error("outputs not at reset values");
  chk_down_mode: assert property (
    (!regulatorGood || !shutdownPinN) [*6] |-> opMode == 2'h0 && sramClear)
    else $error("power-down not entered");
  chk_quiet_down: assert property ((opMode == 2'h0) [*2] |-> !sdaOe)
    else $error("bus answered in power-down");
  chk_leave_down: assert property (sSuppliesUp |-> opMode == 2'h1)
    else $error("standby not reached");
  chk_drive_start: assert property ($rose(playStart) |-> ##[1:2] sDriveOn)
    else $error("drive stages not enabled");
  chk_drive_idle: assert property (
    (opMode == 2'h1) [*3] |-> !boostEnable && !bridgeEnable)
    else $error("drive on in standby");
  chk_engine_end: assert property (
    opMode == 2'h2 && playSource != 2'h0 && engineDone |-> ##[1:3] opMode == 2'h1)
    else $error("no return to standby");
  chk_sram_write: assert property (sramWrEn |-> sramClockOn && opMode == 2'h1)
    else $error("sram write outside clocked standby");
  chk_sample_gap: assert property (
    sampleValid |-> playSource == 2'h0 ##1 !sampleValid)
    else $error("bad sample pacing");
  chk_sram_kept: assert property (
    (regulatorGood && shutdownPinN) [*8] |-> !sramClear)
    else $error("sram wiped while powered");
  chk_detect_clock: assert property (detectRun |-> sramClockOn)
    else $error("detect without sram clock");
endmodule
bind hmd_ctrl hmd_ctrl_props hmd_ctrl_props_i (
  .clk_sys, .rst_n, .regulatorGood, .shutdownPinN, .engineDone, .playStart,
  .playSource, .sampleValid, .sramClockOn, .sramClear, .sramWrEn, .sdaOe,
  .opMode, .boostEnable, .bridgeEnable, .detectRun, .measGain
);
`default_nettype wire

// [verif/hmd_i2c_host.sv]
// behavioural I2C host issuing register and detect traffic
`default_nettype none
module hmd_i2c_host
  import hmd_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // bus, SDA pulled up outside
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  int h = 5;
  // far shorter than the 3 ms settle, keeps the run small
  int detectWait = 2000;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic xbit(input logic b, output logic r);
    w(h);
    sdaLow = !b;
    w(h);
    scl = 1'b1;
    w(h);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic m9, output logic [7:0] q,
                       output logic nak);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(m9, nak);
  endtask
  // also serves as repeated start
  task automatic start;
    w(h);
    sdaLow = 1'b0;
    w(h);
    scl = 1'b1;
    w(h);
    sdaLow = 1'b1;
    w(h);
    scl = 1'b0;
  endtask
  task automatic stop;
    w(h);
    sdaLow = 1'b1;
    w(h);
    scl = 1'b1;
    w(h);
    sdaLow = 1'b0;
    w(h);
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n;
    start();
    xbyte({I2C_DEV_ADDR, 1'b0}, 1'b1, q, nak);
    xbyte(a, 1'b1, q, n);
    xbyte(d, 1'b1, q, n);
    stop();
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic n;
    start();
    xbyte({I2C_DEV_ADDR, 1'b0}, 1'b1, q, n);
    xbyte(a, 1'b1, q, n);
    start();
    xbyte({I2C_DEV_ADDR, 1'b1}, 1'b1, q, n);
    xbyte(8'hFF, 1'b1, d, n);
    stop();
  endtask
  task automatic runDetect(input logic [1:0] seq, input logic [5:0] gain, input logic setGain);
    logic [7:0] saved;
    logic n;
    rdReg(REG_DETECT_CFG, saved);
    wrReg(REG_SRAM_CLK, 8'h01, n);
    wrReg(REG_DETECT_CFG, {setGain ? gain : saved[7:2], seq}, n);
    wrReg(REG_DETECT_CTRL, 8'h80, n);
    w(detectWait);
    wrReg(REG_DETECT_CTRL, 8'h00, n);
    wrReg(REG_SRAM_CLK, 8'h00, n);
    wrReg(REG_DETECT_CFG, saved, n);
  endtask
endmodule
`default_nettype wire

// [verif/test_hmd_ctrl.sv]
// self-checking bench for the haptic mode and detect controller
`default_nettype none
module test_hmd_ctrl
  import hmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] HDR [8] = '{8'h01, 8'h10, 8'h01, 8'h12, 8'h01, 8'h20, 8'h01, 8'h20};
  logic clk_sys, rst_n, regulatorGood, shutdownPinN, sclIn, sdaIn, sdaOut, sdaOe, sdaLow;
  logic measValid, engineDone, playStart, contFiltered, sampleValid, sramClockOn, sramClear;
  logic sramRdEn, sramWrEn, boostEnable, bridgeEnable, detectRun, compEnable, boostSeen, nak;
  logic [2:0] trigPin;
  logic [9:0] measCode;
  logic [1:0] playSource, opMode, detectSeq;
  logic signed [7:0] sampleOut;
  logic [7:0] sramRdData, sramWrData, rd;
  logic [12:0] sramRdAddr, sramWrAddr, fifoBase;
  logic [5:0] measGain;
  logic [6:0] vbatRef;
  logic [7:0] mem [8192];
  logic [7:0] seen [$];
  int errors = 0;
  int samples_checked = 0;
  assign sdaIn = !(sdaLow || (sdaOe && !sdaOut));
  assign sramRdData = sramRdEn ? mem[sramRdAddr] : ~mem[sramRdAddr];
  hmd_ctrl hmd_ctrl_i (
    .clk_sys, .rst_n, .regulatorGood, .shutdownPinN, .trigPin, .sclIn, .sdaIn, .sdaOut,
    .sdaOe, .measCode, .measValid, .engineDone, .playStart, .playSource, .contFiltered,
    .sampleOut, .sampleValid, .sramClockOn, .sramClear, .sramRdAddr, .sramRdEn,
    .sramRdData, .sramWrAddr, .sramWrData, .sramWrEn, .fifoBase, .opMode, .boostEnable,
    .bridgeEnable, .detectRun, .detectSeq, .measGain, .compEnable, .vbatRef
  );
  hmd_i2c_host hmd_i2c_host_i (.clk_sys, .scl(sclIn), .sdaLow, .sda(sdaIn));
  always #10 clk_sys = !clk_sys;
  // external memory and sample capture
  always @(posedge clk_sys) begin
    if (sramWrEn === 1'b1) mem[sramWrAddr] <= sramWrData;
    if (sramClear === 1'b1) foreach (mem[i]) mem[i] <= 8'h00;
    if (sampleValid === 1'b1) seen.push_back(sampleOut);
    if (boostEnable === 1'b1 && bridgeEnable === 1'b1) boostSeen <= 1'b1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hmd_i2c_host_i.wrReg(a, d, nak);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    hmd_i2c_host_i.rdReg(a, rd);
    chk(16'(rd), 16'(exp));
  endtask
  task automatic waitMode(input logic [1:0] m);
    for (int i = 0; i < 400 && opMode !== m; i++) cyc(1);
    chk(16'(opMode), 16'(m));
  endtask
  task automatic ramWr(input logic [12:0] a, input logic [7:0] d);
    wr(REG_RAM_ADDR_HIGH, 8'(a[12:8]));
    wr(REG_RAM_ADDR_LOW, a[7:0]);
    wr(REG_RAM_DATA, d);
    chk(16'(mem[a]), 16'(d));
  endtask
  // n samples packed first-sample-high in e
  task automatic chkSeen(input logic [31:0] e, input int n);
    chk(16'(seen.size()), 16'(n));
    for (int i = 0; i < n && i < seen.size(); i++) chk(16'(seen[i]), 16'(e[8*(n-1-i)+:8]));
    seen.delete();
  endtask
  task automatic feedCode(input logic [9:0] code, input logic [1:0] seq, input logic [5:0] g);
    for (int i = 0; i < 4000 && detectRun !== 1'b1; i++) cyc(1);
    cyc(3);
    chk(16'(detectSeq), 16'(seq));
    chk(16'(measGain), 16'(g));
    measCode = code;
    measValid = 1'b1;
    cyc(1);
    measValid = 1'b0;
    measCode = ~code;
  endtask
  task automatic wrap_up;
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    regulatorGood = 1'b0;
    shutdownPinN = 1'b1;
    trigPin = 3'h0;
    measCode = 10'h000;
    measValid = 1'b0;
    engineDone = 1'b0;
    boostSeen = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    cyc(12);
    chk(16'(opMode), 16'h0);
    chk(16'(sramClear), 16'h1);
    regulatorGood = 1'b1;
    waitMode(2'h1);
    cyc(4);
    chk(16'(sramClear), 16'h0);
    rdChk(REG_DETECT_CFG, 8'h50);
    hmd_i2c_host_i.h = 9;
    rdChk(8'h7F, 8'h00);
    hmd_i2c_host_i.h = 5;
    wr(REG_SRAM_CLK, 8'h01);
    chk(16'(sramClockOn), 16'h1);
    wr(REG_BASE_HIGH, 8'h01);
    wr(REG_BASE_LOW, 8'h00);
    chk(16'(fifoBase), 16'h0100);
    ramWr(13'h100, 8'h5C);
    ramWr(13'h110, 8'h80);
    ramWr(13'h120, 8'h01);
    wr(REG_SRAM_CLK, 8'h00);
    chk(16'(sramClockOn), 16'h0);
    foreach (HDR[i]) mem[13'h101 + 13'(i)] = HDR[i];
    mem[13'h111] = 8'h7F;
    mem[13'h112] = 8'hFF;
    wr(REG_PLAYBACK_MODE_SELECT, 8'h00);
    wr(REG_WAVE_ID, 8'h01);
    wr(REG_PLAY_GO, 8'h01);
    waitMode(2'h1);
    chk(16'(boostSeen), 16'h1);
    chkSeen(32'h0080_7FFF, 3);
    // stream mode selected, yet the trigger must play the library
    wr(REG_PLAYBACK_MODE_SELECT, 8'h01);
    wr(REG_TRIG_ID0 + 8'h01, 8'h02);
    trigPin = 3'b010;
    cyc(8);
    trigPin = 3'h0;
    waitMode(2'h1);
    chkSeen(32'h0000_0001, 1);
    for (int m = 1; m <= 2; m++) begin
      wr(REG_PLAYBACK_MODE_SELECT, (m == 2) ? 8'h06 : 8'h01);
      wr(REG_PLAY_GO, 8'h01);
      cyc(20);
      chk(16'(opMode), 16'h2);
      chk(16'(playSource), 16'(m));
      chk(16'(contFiltered), 16'(m == 2));
      engineDone = 1'b1;
      cyc(1);
      engineDone = 1'b0;
      waitMode(2'h1);
    end
    fork
      hmd_i2c_host_i.runDetect(2'h0, 6'h00, 1'b0);
      feedCode(10'h2B7, 2'h0, 6'h14);
    join
    measValid = 1'b1;
    cyc(1);
    measValid = 1'b0;
    rdChk(REG_MEAS_HIGH, 8'h02);
    rdChk(REG_MEAS_LOW, 8'hB7);
    fork
      hmd_i2c_host_i.runDetect(2'h3, 6'h0A, 1'b1);
      feedCode(10'h155, 2'h3, 6'h0A);
    join
    rdChk(REG_MEAS_HIGH, 8'h01);
    rdChk(REG_MEAS_LOW, 8'h55);
    rdChk(REG_DETECT_CFG, 8'h50);
    wr(REG_DETECT_CTRL, 8'h35);
    wr(REG_COMP_MODE, 8'h01);
    chk(16'(vbatRef), 16'h0035);
    chk(16'(compEnable), 16'h1);
    wr(REG_SOFT_RESET, 8'hAA);
    cyc(4);
    chk(16'(compEnable), 16'h0);
    chk(16'(fifoBase), 16'h0);
    chk(16'(mem[13'h100]), 16'h005C);
    shutdownPinN = 1'b0;
    cyc(8);
    chk(16'(opMode), 16'h0);
    hmd_i2c_host_i.wrReg(REG_COMP_MODE, 8'h01, nak);
    chk(16'(nak), 16'h1);
    chk(16'(mem[13'h100]), 16'h0);
    shutdownPinN = 1'b1;
    waitMode(2'h1);
    chk(16'(compEnable), 16'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
